/* File: runtime_settings_cfg.svh */
// Offsets, field positions, reset values and divider counter width of the settings readback block.
// Assumes inclusion by the package and the design files; definitions only.
`ifndef RUNTIME_SETTINGS_CFG_SVH
`define RUNTIME_SETTINGS_CFG_SVH

// ==========================================================================
// Register byte offsets on the APB bus.
`define RSR_OFS_CHIP     8'h00
`define RSR_OFS_AREALEN  8'h04
`define RSR_OFS_ENABLE   8'h08
`define RSR_OFS_COMMAND  8'h0c
`define RSR_OFS_REPLY0   8'h10
`define RSR_OFS_REPLY1   8'h14
`define RSR_OFS_ISTAT    8'h18
`define RSR_OFS_IMASK    8'h1c

// ==========================================================================
// Reply codes.
`define RSR_CMD_GET      8'h61
`define RSR_STATUS_OK    8'h00

// ==========================================================================
// Field positions of the enable register.
`define RSR_EN_BUS       0
`define RSR_EN_SUSPEND   1
`define RSR_EN_CONFIG    2
`define RSR_EN_CLKOUT    3

// ==========================================================================
// Field positions of the interrupt status and mask registers.
`define RSR_IRQ_REPLY    0
`define RSR_IRQ_EDGE     1
`define RSR_IRQ_BADCMD   2
`define RSR_IRQ_W        3

// ==========================================================================
// Reset values and default area lengths.
`define RSR_RST_CHIP     32'h0000_0000
`define RSR_RST_ENABLE   4'h0
`define RSR_RST_MASK     3'h0
`define RSR_CHIP_LEN     8'h04
`define RSR_PIN_LEN      8'h04

// ==========================================================================
// Clock output divider counter width.
`define RSR_DIV_CNT_W    9

`endif

/* File: runtime_settings_pkg.sv */
// Types shared by the settings readback block and its clock output divider.
// Assumes the constants header is available by its bare name.
`include "runtime_settings_cfg.svh"

package runtime_settings_pkg;

  // ========================================================================
  // Security mode codes.
  typedef enum logic [1:0] {
    SEC_UNSECURED = 2'b00,
    SEC_PASSWORD  = 2'b01,
    SEC_LOCKED    = 2'b10,
    SEC_RESERVED  = 2'b11
  } security_mode_t;

  // ========================================================================
  // Chip settings, reply bytes 4 to 7, byte 4 in the low bits.
  typedef struct packed {
    logic           intSpare;
    logic           intFallEn;
    logic           intRiseEn;
    logic [4:0]     adcBits;
    logic [1:0]     dacRefLevel;
    logic           dacRefInternal;
    logic [4:0]     dacPowerUp;
    logic [2:0]     clkSpare;
    logic [1:0]     clkDuty;
    logic [2:0]     clkDiv;
    logic           serialEn;
    logic           rxIdle;
    logic           txIdle;
    logic           busIdle;
    logic           suspIdle;
    logic           cfgIdle;
    security_mode_t security;
  } chip_settings_t;

  // ========================================================================
  // Whole reply, byte 0 in the low bits.
  typedef struct packed {
    chip_settings_t settings;
    logic [7:0]     pinLen;
    logic [7:0]     chipLen;
    logic [7:0]     status;
    logic [7:0]     echo;
  } reply_t;

  // ========================================================================
  // Command sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BUILD = 2'b01
  } cmd_state_t;

endpackage : runtime_settings_pkg

/* File: clock_out_divider.sv */
// Divides the block clock for the clock output pin with a selectable duty cycle.
// Assumes divide and duty selections come from registers in the same clock domain.
`timescale 1ns/1ps
`include "runtime_settings_cfg.svh"

module clock_out_divider
  import runtime_settings_pkg::*;
#(
  parameter int CNT_W = `RSR_DIV_CNT_W
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       enable,
  input  wire logic [2:0] divSel,
  input  wire logic [1:0] dutySel,
  output logic            clkOut
);

  // ========================================================================
  // Parameter check.
  if (CNT_W < 9) begin : g_bad_width
    $error("clock_out_divider needs CNT_W of at least 9");
  end

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] highTime;
  logic [CNT_W-1:0] quarter;
  logic [CNT_W-1:0] count_nxt;

  // ========================================================================
  // Period is 2 to 256 cycles; duty 00 half, 01 quarter, 10 three quarters.
  assign period    = CNT_W'(9'h002) << divSel;
  assign quarter   = (period >> 2) == '0 ? CNT_W'(9'h001) : (period >> 2);
  assign highTime  = (dutySel == 2'b01) ? quarter :
                     (dutySel == 2'b10) ? CNT_W'(period - quarter) : (period >> 1);
  assign count_nxt = (!enable || count_r >= CNT_W'(period - CNT_W'(9'h001))) ?
                     '0 : CNT_W'(count_r + CNT_W'(9'h001));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= '0;
      clkOut  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      clkOut  <= enable && (count_nxt < highTime);
    end
  end

endmodule : clock_out_divider

/* File: runtime_settings_readback.sv */
// Overview of operation
// - Reply byte 0 echoes command 0x61, byte 1 reports success 0x00.
// - Reply byte 2 gives the chip settings area length in bytes.
// - Reply byte 3 gives the pin settings area length in bytes.
// - Byte 4 bit 7 enables the serial-number descriptor at enumeration.
// - Receive indicator idles at byte 4 bit 6, inverts while receiving.
// - Transmit indicator idles at byte 4 bit 5, inverts while sending.
// - Enabled bus indicator idles at byte 4 bit 4, inverts on traffic.
// - Enabled suspend indicator idles at byte 4 bit 3, inverts in suspend.
// - Enabled configured indicator holds byte 4 bit 2, inverts once configured.
// - Byte 4 bits 1-0 give security: 10 locked, 01 password, 00 open.
// - Clock output pin carries the block clock divided per byte 5 bits 4-0.
// - Clock setting bits 4-3 pick duty cycle, bits 2-0 division ratio.
// - Byte 6 bits 7-6 pick reference level 4.096, 2.048, 1.024 or off.
// - Byte 6 bit 5 picks internal reference when set, supply when clear.
// - Byte 6 bits 4-0 hold the analog output power-up value.
// - Byte 7 bit 6 set makes falling input edges set the detection flag.
// - Byte 7 bit 5 set makes rising input edges set the detection flag.
//
// Settings readback block with APB register access, indicator pins and edge detection.
// Assumes a 250 MHz ref_clk, pins from outside the clock domain, and an APB master.
`timescale 1ns/1ps
`include "runtime_settings_cfg.svh"

module runtime_settings_readback
  import runtime_settings_pkg::*;
#(
  parameter logic [7:0] CHIP_AREA_LEN = `RSR_CHIP_LEN,
  parameter logic [7:0] PIN_AREA_LEN  = `RSR_PIN_LEN
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        rxBusy,
  input  wire logic        txBusy,
  input  wire logic        busActive,
  input  wire logic        suspended,
  input  wire logic        usbConfigured,
  input  wire logic        intPin,
  output logic             rxActivityIndicator,
  output logic             txActivityIndicator,
  output logic             busActivityIndicator,
  output logic             suspendIndicator,
  output logic             configuredIndicator,
  output logic             serialNumberEnable,
  output security_mode_t   securityMode,
  output logic [1:0]       dacRefLevel,
  output logic             dacRefInternal,
  output logic [4:0]       dacPowerUpValue,
  output logic             clockOut,
  output logic             irq
);

  // ==========================================================================
  // Parameter check.
  if (CHIP_AREA_LEN == 8'h00) begin : g_bad_len
    $error("runtime_settings_readback needs a non-zero chip area length");
  end

  // ==========================================================================
  // Declarations.
  chip_settings_t           settings_r;
  logic [3:0]               enable_r;
  logic [`RSR_IRQ_W-1:0]    istat_r;
  logic [`RSR_IRQ_W-1:0]    istat_nxt;
  logic [`RSR_IRQ_W-1:0]    imask_r;
  logic [`RSR_IRQ_W-1:0]    events;
  reply_t                   reply_r;
  cmd_state_t               state_r;
  cmd_state_t               state_nxt;
  logic [5:0]               pinMeta_r;
  logic [5:0]               pinSync_r;
  logic                     intLast_r;
  logic                     setupPhase;
  logic                     accessDone;
  logic                     wrDone;
  logic                     hitChip;
  logic                     hitAreaLen;
  logic                     hitEnable;
  logic                     hitCommand;
  logic                     hitReply0;
  logic                     hitReply1;
  logic                     hitIstat;
  logic                     hitImask;
  logic                     hitAny;
  logic [31:0]              readMux;
  logic                     cmdWrite;
  logic                     cmdGood;
  logic                     rxSync;
  logic                     txSync;
  logic                     busSync;
  logic                     suspSync;
  logic                     cfgSync;
  logic                     intSync;
  logic                     riseEdge;
  logic                     fallEdge;
  logic                     edgeEvent;
  logic                     divClk;
  logic                     busShown;
  logic                     suspShown;
  logic                     cfgShown;

  // ==========================================================================
  // APB decode.
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign wrDone     = accessDone && pwrite;
  assign hitChip    = paddr == `RSR_OFS_CHIP;
  assign hitAreaLen = paddr == `RSR_OFS_AREALEN;
  assign hitEnable  = paddr == `RSR_OFS_ENABLE;
  assign hitCommand = paddr == `RSR_OFS_COMMAND;
  assign hitReply0  = paddr == `RSR_OFS_REPLY0;
  assign hitReply1  = paddr == `RSR_OFS_REPLY1;
  assign hitIstat   = paddr == `RSR_OFS_ISTAT;
  assign hitImask   = paddr == `RSR_OFS_IMASK;
  assign hitAny     = hitChip || hitAreaLen || hitEnable || hitCommand ||
                      hitReply0 || hitReply1 || hitIstat || hitImask;
  assign readMux    = hitChip    ? settings_r :
                      hitAreaLen ? {16'h0000, PIN_AREA_LEN, CHIP_AREA_LEN} :
                      hitEnable  ? {28'h0000000, enable_r} :
                      hitReply0  ? reply_r[31:0] :
                      hitReply1  ? reply_r[63:32] :
                      hitIstat   ? {29'h0000000, istat_r} :
                      hitImask   ? {29'h0000000, imask_r} : 32'h00000000;

  // ==========================================================================
  // APB answer: one setup cycle, then an access cycle with pready high.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      prdata  <= (setupPhase && !pwrite) ? readMux : 32'h00000000;
      pslverr <= setupPhase && !hitAny;
    end
  end

  // ==========================================================================
  // Settings, enables and mask registers.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      settings_r <= `RSR_RST_CHIP;
      enable_r   <= `RSR_RST_ENABLE;
      imask_r    <= `RSR_RST_MASK;
    end else begin
      if (wrDone && hitChip) begin
        settings_r <= pwdata;
      end
      if (wrDone && hitEnable) begin
        enable_r <= pwdata[3:0];
      end
      if (wrDone && hitImask) begin
        imask_r <= pwdata[`RSR_IRQ_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Command sequencer.
  assign cmdWrite = wrDone && hitCommand;
  assign cmdGood  = cmdWrite && (pwdata[7:0] == `RSR_CMD_GET);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cmdGood) begin
          state_nxt = ST_BUILD;
        end
      end
      ST_BUILD: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      reply_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_BUILD) begin
        reply_r.echo     <= `RSR_CMD_GET;
        reply_r.status   <= `RSR_STATUS_OK;
        reply_r.chipLen  <= CHIP_AREA_LEN;
        reply_r.pinLen   <= PIN_AREA_LEN;
        reply_r.settings <= settings_r;
      end
    end
  end

  // ==========================================================================
  // Pin synchronisers; the first rank feeds only the second.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_r <= 6'h00;
      pinSync_r <= 6'h00;
      intLast_r <= 1'b0;
    end else begin
      pinMeta_r <= {intPin, usbConfigured, suspended, busActive, txBusy, rxBusy};
      pinSync_r <= pinMeta_r;
      intLast_r <= pinSync_r[5];
    end
  end

  assign rxSync   = pinSync_r[0];
  assign txSync   = pinSync_r[1];
  assign busSync  = pinSync_r[2];
  assign suspSync = pinSync_r[3];
  assign cfgSync  = pinSync_r[4];
  assign intSync  = pinSync_r[5];

  // ==========================================================================
  // Edge detection on the interrupt input.
  assign riseEdge  = settings_r.intRiseEn && intSync && !intLast_r;
  assign fallEdge  = settings_r.intFallEn && !intSync && intLast_r;
  assign edgeEvent = riseEdge || fallEdge;

  // ==========================================================================
  // Sticky status, write one to clear, a new event wins over the clear.
  assign events = {cmdWrite && !cmdGood, edgeEvent, state_r == ST_BUILD};
  assign istat_nxt = (istat_r & ~((wrDone && hitIstat) ? pwdata[`RSR_IRQ_W-1:0] :
                     {`RSR_IRQ_W{1'b0}})) | events;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      istat_r <= {`RSR_IRQ_W{1'b0}};
      irq     <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      irq     <= |(istat_nxt & imask_r);
    end
  end

  // ==========================================================================
  // Indicator and setting outputs.
  assign busShown  = enable_r[`RSR_EN_BUS] && busSync;
  assign suspShown = enable_r[`RSR_EN_SUSPEND] && suspSync;
  assign cfgShown  = enable_r[`RSR_EN_CONFIG] && cfgSync;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxActivityIndicator  <= 1'b0;
      txActivityIndicator  <= 1'b0;
      busActivityIndicator <= 1'b0;
      suspendIndicator     <= 1'b0;
      configuredIndicator  <= 1'b0;
      serialNumberEnable   <= 1'b0;
      securityMode         <= SEC_UNSECURED;
      dacRefLevel          <= 2'h0;
      dacRefInternal       <= 1'b0;
      dacPowerUpValue      <= 5'h00;
    end else begin
      rxActivityIndicator  <= settings_r.rxIdle ^ rxSync;
      txActivityIndicator  <= settings_r.txIdle ^ txSync;
      busActivityIndicator <= settings_r.busIdle ^ busShown;
      suspendIndicator     <= settings_r.suspIdle ^ suspShown;
      configuredIndicator  <= settings_r.cfgIdle ^ cfgShown;
      serialNumberEnable   <= settings_r.serialEn;
      securityMode         <= settings_r.security;
      dacRefLevel          <= settings_r.dacRefLevel;
      dacRefInternal       <= settings_r.dacRefInternal;
      dacPowerUpValue      <= settings_r.dacPowerUp;
    end
  end

  // ==========================================================================
  // Clock output divider.
  clock_out_divider #(
    .CNT_W   (`RSR_DIV_CNT_W)
  ) u_divider (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .enable  (enable_r[`RSR_EN_CLKOUT]),
    .divSel  (settings_r.clkDiv),
    .dutySel (settings_r.clkDuty),
    .clkOut  (divClk)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clockOut <= 1'b0;
    end else begin
      clockOut <= divClk;
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  chk_reply_echo: assert property (
    state_r == ST_BUILD |=> reply_r.echo == 8'h61 && reply_r.status == 8'h00 && istat_r[0])
    else $error("reply echo or status wrong after build");

  chk_area_lengths: assert property (
    state_r == ST_BUILD |=> reply_r.chipLen == CHIP_AREA_LEN && reply_r.pinLen == PIN_AREA_LEN)
    else $error("reply area lengths wrong");

  chk_reply_snapshot: assert property (
    cmdGood |-> ##2 reply_r.settings == $past(settings_r, 1))
    else $error("reply does not hold the settings in effect");

  chk_serial_enable: assert property (
    wrDone && hitChip |-> ##2 serialNumberEnable == $past(pwdata[7], 2))
    else $error("serial number enable does not follow the setting");

  chk_rx_indicator: assert property (
    $stable(settings_r) [*3] |->
      rxActivityIndicator == ($past(settings_r.rxIdle) ^ $past(rxBusy, 3)))
    else $error("receive indicator level wrong");

  chk_tx_indicator: assert property (
    $stable(settings_r) [*3] |->
      txActivityIndicator == ($past(settings_r.txIdle) ^ $past(txBusy, 3)))
    else $error("transmit indicator level wrong");

  chk_susp_indicator: assert property (
    !enable_r[`RSR_EN_SUSPEND] && $stable(enable_r) && $stable(settings_r)
      |=> suspendIndicator == $past(settings_r.suspIdle))
    else $error("disabled suspend indicator left its idle level");

  chk_rise_flag: assert property (
    settings_r.intRiseEn && $rose(pinSync_r[5]) |=> istat_r[1])
    else $error("rising edge did not set the detection flag");

  chk_fall_flag: assert property (
    settings_r.intFallEn && $fell(pinSync_r[5]) |=> istat_r[1])
    else $error("falling edge did not set the detection flag");

  chk_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not exactly one access cycle");

  chk_irq_level: assert property (
    ##1 irq == |($past(istat_nxt) & $past(imask_r)))
    else $error("interrupt output does not follow unmasked status");

endmodule : runtime_settings_readback

/* File: runtime_settings_host.sv */
// APB host model that sends the settings command and reads registers.
// Assumes the device shares ref_clk; each access waits for pready, the bench bounds the wait.
`timescale 1ns/1ps
`include "runtime_settings_cfg.svh"

module runtime_settings_host (
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // ==========================================================================
  // Bus cycles.
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask : xfer

  // Sends the read-settings command code.
  task automatic getSettings(output logic err);
    logic [31:0] q;
    xfer(1'b1, `RSR_OFS_COMMAND, {24'h0, `RSR_CMD_GET}, q, err);
  endtask : getSettings

  // Hides reply bit 31 (spare) and bits 23-21 (reference level and select).
  function automatic logic [31:0] visible(input logic [31:0] w);
    return w & 32'h7f1f_ffff;
  endfunction : visible
endmodule : runtime_settings_host

/* File: test_runtime_settings_readback.sv */
// Self-checking bench for the settings readback block.
// Assumes the host model owns the APB side; the bench drives status pins and reset.
`timescale 1ns/1ps
`include "runtime_settings_cfg.svh"

module test_runtime_settings_readback
  import runtime_settings_pkg::*;
;
  localparam logic [7:0]  CHIP_LEN = 8'h04;
  localparam logic [7:0]  PIN_LEN  = 8'h0c;
  localparam logic [31:0] REPLY0   = {PIN_LEN, CHIP_LEN, `RSR_STATUS_OK, `RSR_CMD_GET};

  typedef struct packed {
    logic [31:0]    chip;
    logic           serial;
    security_mode_t sec;
    logic [1:0]     level;
    logic           internal;
    logic [4:0]     powerUp;
  } row_t;

  logic           ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, err, intPin, irq;
  logic           rxActivityIndicator, txActivityIndicator, busActivityIndicator;
  logic           suspendIndicator, configuredIndicator, serialNumberEnable;
  logic           dacRefInternal, clockOut;
  security_mode_t securityMode;
  logic [1:0]     dacRefLevel;
  logic [4:0]     dacPowerUpValue, act, exp5;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rdata, chip;
  int             nFail = 0, checksDone = 0, i, k, cnt;
  int             hi[4] = '{8, 4, 12, 8};
  row_t           rows[4] = '{
    '{32'h0000_0082, 1'b1, SEC_LOCKED,    2'b00, 1'b0, 5'h00},
    '{32'h80ff_e001, 1'b0, SEC_PASSWORD,  2'b11, 1'b1, 5'h1f},
    '{32'h4093_1f7c, 1'b0, SEC_UNSECURED, 2'b10, 1'b0, 5'h13},
    '{32'h2075_0000, 1'b0, SEC_UNSECURED, 2'b01, 1'b1, 5'h15}
  };
  wire logic [4:0]  ind = {rxActivityIndicator, txActivityIndicator, busActivityIndicator,
                           suspendIndicator, configuredIndicator};
  wire logic [10:0] chipPins = {serialNumberEnable, securityMode, dacRefLevel, dacRefInternal,
                                dacPowerUpValue};

  runtime_settings_readback #(.CHIP_AREA_LEN(CHIP_LEN), .PIN_AREA_LEN(PIN_LEN)) dut_u (
    .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .rxBusy(act[4]), .txBusy(act[3]), .busActive(act[2]), .suspended(act[1]),
    .usbConfigured(act[0]), .intPin, .rxActivityIndicator, .txActivityIndicator,
    .busActivityIndicator, .suspendIndicator, .configuredIndicator, .serialNumberEnable,
    .securityMode, .dacRefLevel, .dacRefInternal, .dacPowerUpValue, .clockOut, .irq
  );
  runtime_settings_host host_u (
    .ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr
  );

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  // ==========================================================================
  // Helpers.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rdata, err);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    host_u.xfer(1'b0, a, 32'h0, rdata, err);
  endtask : rd

  task automatic checkReg(input logic [31:0] got, input logic [31:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : checkReg

  task automatic checkPin(input logic [10:0] got, input logic [10:0] exp, input string what);
    checkReg({21'h0, got}, {21'h0, exp}, what);
  endtask : checkPin

  task automatic resetCheck();
    rd(`RSR_OFS_CHIP);
    checkReg(rdata, `RSR_RST_CHIP, "chip reset");
    rd(`RSR_OFS_REPLY1);
    checkReg(rdata, 32'h0, "reply reset");
    rd(`RSR_OFS_AREALEN);
    checkReg(rdata, {16'h0, PIN_LEN, CHIP_LEN}, "area lengths");
    checkPin({10'h0, irq}, 11'h0, "irq reset");
  endtask : resetCheck

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    #(4 * 20000);
    nFail++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    close_out();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    rst_b = 1'b0;
    act = 5'h00;
    intPin = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    resetCheck();
    for (i = 0; i < 4; i++) begin
      wr(`RSR_OFS_CHIP, rows[i].chip);
      repeat (2) @(posedge ref_clk);
      checkPin(chipPins, rows[i][10:0], "pins");
      host_u.getSettings(err);
      wr(`RSR_OFS_CHIP, ~rows[i].chip);
      rd(`RSR_OFS_REPLY0);
      checkReg(rdata, REPLY0, "reply head");
      rd(`RSR_OFS_REPLY1);
      checkReg(host_u.visible(rdata), host_u.visible(rows[i].chip), "reply body");
    end
    for (k = 0; k < 8; k++) begin
      chip = k[0] ? 32'h0000_007c : 32'h0;
      wr(`RSR_OFS_CHIP, chip);
      wr(`RSR_OFS_ENABLE, {29'h0, {3{k[2]}}});
      act <= k[1] ? 5'h1f : 5'h15;
      repeat (6) @(posedge ref_clk);
      exp5 = chip[6:2] ^ (act & {2'b11, {3{k[2]}}});
      checkPin({6'h0, ind}, {6'h0, exp5}, "leds");
    end
    act <= 5'h00;
    for (k = 0; k < 4; k++) begin
      wr(`RSR_OFS_CHIP, 32'(k) << 29);
      wr(`RSR_OFS_ISTAT, 32'h7);
      intPin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd(`RSR_OFS_ISTAT);
      checkReg(rdata & 32'h2, 32'(k[0]) << 1, "rise flag");
      wr(`RSR_OFS_ISTAT, 32'h7);
      intPin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd(`RSR_OFS_ISTAT);
      checkReg(rdata & 32'h2, 32'(k[1]) << 1, "fall flag");
    end
    wr(`RSR_OFS_ISTAT, 32'h7);
    wr(`RSR_OFS_IMASK, 32'h1);
    host_u.getSettings(err);
    repeat (2) @(posedge ref_clk);
    checkPin({10'h0, irq}, 11'h1, "irq set");
    wr(`RSR_OFS_ISTAT, 32'h1);
    repeat (2) @(posedge ref_clk);
    checkPin({10'h0, irq}, 11'h0, "irq clear");
    wr(`RSR_OFS_CHIP, 32'h0);
    wr(`RSR_OFS_COMMAND, 32'h0000_0055);
    repeat (2) @(posedge ref_clk);
    checkPin({10'h0, irq}, 11'h0, "irq masked");
    rd(`RSR_OFS_ISTAT);
    checkReg(rdata & 32'h4, 32'h4, "bad command");
    rd(`RSR_OFS_REPLY0);
    checkReg(rdata, REPLY0, "reply kept");
    rd(`RSR_OFS_REPLY1);
    checkReg(rdata, 32'h6000_0000, "reply body kept");
    wr(`RSR_OFS_AREALEN, 32'hffff_ffff);
    rd(`RSR_OFS_AREALEN);
    checkReg(rdata, {16'h0, PIN_LEN, CHIP_LEN}, "area ro");
    rd(8'h20);
    checkReg({31'h0, err}, 32'h1, "unmapped err");
    checkReg(rdata, 32'h0, "unmapped data");
    wr(`RSR_OFS_ENABLE, 32'h8);
    for (k = 0; k < 4; k++) begin
      wr(`RSR_OFS_CHIP, {16'h0, 3'h0, k[1:0], 3'h1, 8'h0});
      repeat (8) @(posedge ref_clk);
      cnt = 0;
      repeat (16) begin
        @(negedge ref_clk);
        cnt += clockOut;
      end
      checkReg(32'(cnt), 32'(hi[k]), "clock duty");
    end
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    resetCheck();
    close_out();
  end
endmodule : test_runtime_settings_readback
